// ==== core/geometry_and_media_cmds.v ====
// Command interpreter for geometry, eject and lock commands behind an AXI4-Lite slave
//
// Notes on behaviour
// RULE1: Geometry command runs regardless of accepting flag
// RULE2: Store sectors per track and max head
// RULE3: Default translation from words 1,3,6 supported
// RULE4: Unsupported translation aborts with rejected flag
// RULE5: Rejection clears word 53 bit 0, zeroes 54-58
// RULE6: No valid translation fails media access, tag-missing
// RULE7: Words 1,3,6 and capacity stay unchanged
// RULE8: Word 55 is heads plus one, 56 sectors
// RULE9: Word 54 is clamped capped quotient
// RULE10: Words 57-58 are product of 54,55,56
// RULE11: Success clears busy, fault, transfer, error summary
// RULE12: Eject completion reports accepting flag set
// RULE13: Error completion: fault if faulted, summary from errors
// RULE14: Rejected flag may flag any failed action
// RULE15: Unit select bit reflects selected device
// RULE16: Eject is opcode EDh, non-data
// RULE17: Unsupported eject completes as aborted
// RULE18: Eject without medium sets medium absent flag
// RULE19: Eject waits, spins down, unlocks, ejects
// RULE20: Host issues eject and lock only when accepting
// RULE21: Lock is opcode DEh, non-data
// RULE22: Host gives sectors and max head for geometry
// RULE23: Results settle before busy is cleared
`timescale 1ns/1ps
`default_nettype none
`include "geom_media_defines.vh"

module geometry_and_media_cmds #(
	parameter [31:0] CAPACITY = `DEF_CAPACITY
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        medium_present,
	input  wire        ops_pending,
	input  wire        spindle_stopped,
	input  wire        unit_fault,
	output reg         spin_down_req,
	output reg         eject_pulse
);

	// ************************************************************
	// States
	// ************************************************************
	localparam [2:0] S_IDLE   = 3'd0;
	localparam [2:0] S_DIVIDE = 3'd1;
	localparam [2:0] S_STORE  = 3'd2;
	localparam [2:0] S_EJ_OPS = 3'd3;
	localparam [2:0] S_EJ_SPIN = 3'd4;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	reg  [3:0] pin_s1;
	reg  [3:0] pin_s2;
	wire       medium_s;
	wire       pending_s;
	wire       stopped_s;
	wire       fault_s;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end else begin
			pin_s1 <= {unit_fault, spindle_stopped, ops_pending, medium_present};
			pin_s2 <= pin_s1;
		end
	end

	assign medium_s  = pin_s2[0];
	assign pending_s = pin_s2[1];
	assign stopped_s = pin_s2[2];
	assign fault_s   = pin_s2[3];

	// ************************************************************
	// State
	// ************************************************************
	reg  [2:0]  state;
	reg  [7:0]  fault_detail;
	reg         cmd_in_progress;
	reg         unit_accepting_cmds;
	reg         unit_fault_flag;
	reg  [7:0]  unit_and_head_select;
	reg  [7:0]  track_sectors;
	reg  [1:0]  feature_ctrl;
	reg         media_locked;
	reg         xlate_valid;
	reg  [15:0] word54;
	reg  [15:0] word55;
	reg  [15:0] word56;
	reg  [31:0] word57_58;
	reg  [7:0]  req_sectors;
	reg  [3:0]  req_head;
	reg         div_start;
	wire        div_done;
	wire [23:0] div_quot;
	wire [23:0] cap_clamped;
	wire [11:0] geom_product;
	wire [15:0] quot_clamped;
	wire [4:0]  heads_plus_one;
	wire [7:0]  completion_flags;
	wire        wr_go;
	wire        cmd_go;

	// No data phase in any of these commands
	assign completion_flags = {cmd_in_progress, unit_accepting_cmds, unit_fault_flag, 1'b0,
		1'b0, 2'b00, |fault_detail}; // RULE13

	assign cap_clamped    = (CAPACITY > {8'h00, `GEOM_CAP_LIMIT}) ?
		`GEOM_CAP_LIMIT : CAPACITY[23:0]; // RULE9
	assign heads_plus_one = {1'b0, req_head} + 5'h01;
	assign geom_product   = {7'h00, heads_plus_one} * {4'h0, req_sectors};
	assign quot_clamped   = (div_quot > `GEOM_W54_LIMIT) ? 16'hffff : div_quot[15:0]; // RULE9

	seq_divider #(
		.N(24),
		.D(12)
	) u_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (div_start),
		.dividend (cap_clamped),
		.divisor  (geom_product),
		.done     (div_done),
		.quotient (div_quot)
	);

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	// Address and data are taken together, which keeps the decode simple
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign cmd_go        = wr_go && (s_axi_awaddr[7:2] == `OFF_OPCODE_ENTRY >> 2) &&
		s_axi_wstrb[0] && !cmd_in_progress;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			case (s_axi_awaddr[7:2])
				`OFF_UNIT_HEAD_SELECT >> 2,
				`OFF_OPCODE_ENTRY >> 2,
				`OFF_TRACK_SECTORS >> 2,
				`OFF_FEATURE_CTRL >> 2: s_axi_bresp <= `RESP_OKAY;
				default: s_axi_bresp <= `RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Command engine
	// ************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			state                <= S_IDLE;
			fault_detail         <= 8'h00;
			cmd_in_progress      <= 1'b0;
			unit_accepting_cmds  <= 1'b1;
			unit_fault_flag      <= 1'b0;
			unit_and_head_select <= 8'h00;
			track_sectors        <= 8'h00;
			feature_ctrl         <= `DEF_FEATURE_CTRL;
			media_locked         <= 1'b0;
			xlate_valid          <= 1'b1;
			word54               <= `DEF_CYLINDERS;
			word55               <= {8'h00, `DEF_HEADS};
			word56               <= {8'h00, `DEF_SECTORS};
			word57_58            <= `DEF_CYLINDERS * `DEF_HEADS * `DEF_SECTORS;
			req_sectors          <= 8'h00;
			req_head             <= 4'h0;
			div_start            <= 1'b0;
			spin_down_req        <= 1'b0;
			eject_pulse          <= 1'b0;
		end else begin
			div_start   <= 1'b0;
			eject_pulse <= 1'b0;
			// Task-file inputs are frozen while a command runs
			if (wr_go && s_axi_wstrb[0] && !cmd_in_progress) begin
				if (s_axi_awaddr[7:2] == `OFF_UNIT_HEAD_SELECT >> 2)
					unit_and_head_select <= s_axi_wdata[7:0]; // RULE15
				if (s_axi_awaddr[7:2] == `OFF_TRACK_SECTORS >> 2)
					track_sectors <= s_axi_wdata[7:0];
				if (s_axi_awaddr[7:2] == `OFF_FEATURE_CTRL >> 2)
					feature_ctrl <= s_axi_wdata[1:0];
			end
			case (state)
				S_IDLE: begin
					if (cmd_go) begin
						cmd_in_progress <= 1'b1;
						unit_fault_flag <= 1'b0;
						fault_detail    <= 8'h00;
						case (s_axi_wdata[7:0])
							// Taken whatever the accepting flag shows
							`OP_SET_GEOMETRY: begin // RULE1
								req_sectors <= track_sectors; // RULE2 RULE22
								req_head    <= unit_and_head_select[3:0]; // RULE2 RULE22
								if (track_sectors == 8'h00 ||
										track_sectors > `MAX_TRACK_SECTORS) begin
									// Zero sectors would divide by zero
									fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE4
									xlate_valid     <= 1'b0; // RULE5
									word54          <= 16'h0000; // RULE5
									word55          <= 16'h0000; // RULE5
									word56          <= 16'h0000; // RULE5
									word57_58       <= 32'h00000000; // RULE5
									unit_fault_flag <= fault_s; // RULE13
									cmd_in_progress <= 1'b0; // RULE23
								end else begin
									div_start <= 1'b1;
									state     <= S_DIVIDE;
								end
							end
							`OP_EJECT: begin // RULE16
								if (!feature_ctrl[`FC_EJECT_EN]) begin
									fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE17
									unit_accepting_cmds <= 1'b1; // RULE12
									unit_fault_flag     <= fault_s; // RULE13
									cmd_in_progress     <= 1'b0;
								end else if (!medium_s) begin
									fault_detail[`ER_MEDIUM_ABSENT] <= 1'b1; // RULE18
									unit_accepting_cmds <= 1'b1; // RULE12
									unit_fault_flag     <= fault_s; // RULE13
									cmd_in_progress     <= 1'b0;
								end else begin
									state <= S_EJ_OPS; // RULE19
								end
							end
							`OP_LOCK: begin // RULE21
								if (!feature_ctrl[`FC_LOCK_EN] || fault_s)
									fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE14
								else if (!medium_s)
									fault_detail[`ER_MEDIUM_ABSENT] <= 1'b1;
								else
									media_locked <= 1'b1; // RULE21
								unit_fault_flag <= fault_s; // RULE13
								cmd_in_progress <= 1'b0;
							end
							`OP_MEDIA_READ, `OP_MEDIA_WRITE: begin
								if (!xlate_valid)
									fault_detail[`ER_SECTOR_TAG] <= 1'b1; // RULE6
								else
									fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE14
								unit_fault_flag <= fault_s; // RULE13
								cmd_in_progress <= 1'b0;
							end
							default: begin
								fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE14
								unit_fault_flag <= fault_s; // RULE13
								cmd_in_progress <= 1'b0;
							end
						endcase
					end
				end
				S_DIVIDE: begin
					if (div_done) begin
						word54 <= quot_clamped; // RULE9
						word55 <= {11'h000, heads_plus_one}; // RULE8
						word56 <= {8'h00, req_sectors}; // RULE8
						state  <= S_STORE;
					end
				end
				S_STORE: begin
					// Product taken one cycle later so 54-56 are final first
					word57_58 <= word54 * {4'h0, geom_product}; // RULE10
					xlate_valid <= 1'b1;
					if (fault_s) begin
						fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE14
						unit_fault_flag <= 1'b1; // RULE13
					end
					cmd_in_progress <= 1'b0; // RULE11 RULE23
					state <= S_IDLE;
				end
				S_EJ_OPS: begin
					// Outstanding media work must finish before the spindle stops
					if (!pending_s) begin
						spin_down_req <= 1'b1; // RULE19
						state <= S_EJ_SPIN;
					end
				end
				S_EJ_SPIN: begin
					if (stopped_s) begin
						spin_down_req <= 1'b0;
						media_locked  <= 1'b0; // RULE19
						eject_pulse   <= 1'b1; // RULE19
						if (fault_s) begin
							fault_detail[`ER_CMD_REJECTED] <= 1'b1; // RULE14
							unit_fault_flag <= 1'b1; // RULE13
						end
						unit_accepting_cmds <= 1'b1; // RULE12
						cmd_in_progress     <= 1'b0; // RULE11 RULE23
						state <= S_IDLE;
					end
				end
				default: begin
					cmd_in_progress <= 1'b0;
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			case (s_axi_araddr[7:2])
				`OFF_FAULT_DETAIL >> 2:     s_axi_rdata <= {24'h000000, fault_detail};
				`OFF_COMPLETION_FLAGS >> 2: s_axi_rdata <= {24'h000000, completion_flags};
				`OFF_UNIT_HEAD_SELECT >> 2: s_axi_rdata <= {24'h000000, unit_and_head_select};
				`OFF_OPCODE_ENTRY >> 2:     s_axi_rdata <= 32'h00000000;
				`OFF_TRACK_SECTORS >> 2:    s_axi_rdata <= {24'h000000, track_sectors};
				`OFF_FEATURE_CTRL >> 2:
					s_axi_rdata <= {23'h000000, media_locked, 6'h00, feature_ctrl};
				`OFF_CAPACITY >> 2:         s_axi_rdata <= CAPACITY; // RULE7
				`OFF_WORD53 >> 2:           s_axi_rdata <= {31'h00000000, xlate_valid}; // RULE5
				`OFF_WORD54 >> 2:           s_axi_rdata <= {16'h0000, word54};
				`OFF_WORD55 >> 2:           s_axi_rdata <= {16'h0000, word55};
				`OFF_WORD56 >> 2:           s_axi_rdata <= {16'h0000, word56};
				`OFF_WORD57_58 >> 2:        s_axi_rdata <= word57_58;
				`OFF_DEFAULT_GEOM >> 2:     // RULE3 RULE7
					s_axi_rdata <= {`DEF_CYLINDERS, `DEF_HEADS, `DEF_SECTORS};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // geometry_and_media_cmds

`default_nettype wire

// ==== core/geom_media_defines.vh ====
// Register map, field positions, opcodes and default geometry of the command block
`ifndef GEOM_MEDIA_DEFINES_VH
`define GEOM_MEDIA_DEFINES_VH

`define OFF_FAULT_DETAIL     8'h00
`define OFF_COMPLETION_FLAGS 8'h04
`define OFF_UNIT_HEAD_SELECT 8'h08
`define OFF_OPCODE_ENTRY     8'h0c
`define OFF_TRACK_SECTORS    8'h10
`define OFF_FEATURE_CTRL     8'h14
`define OFF_CAPACITY         8'h18
`define OFF_WORD53           8'h1c
`define OFF_WORD54           8'h20
`define OFF_WORD55           8'h24
`define OFF_WORD56           8'h28
`define OFF_WORD57_58        8'h2c
`define OFF_DEFAULT_GEOM     8'h30

`define ST_CMD_IN_PROGRESS   7
`define ST_ACCEPTING         6
`define ST_FAULT             5
`define ST_TRANSFER_REQ      3
`define ST_ERROR_SUMMARY     0

`define ER_SECTOR_TAG        4
`define ER_CMD_REJECTED      2
`define ER_MEDIUM_ABSENT     1

`define UH_UNIT_SELECT       4
`define FC_EJECT_EN          0
`define FC_LOCK_EN           1
`define FC_LOCKED            8

`define OP_SET_GEOMETRY      8'h91
`define OP_EJECT             8'hed
`define OP_LOCK              8'hde
`define OP_MEDIA_READ        8'h20
`define OP_MEDIA_WRITE       8'h30

`define GEOM_CAP_LIMIT       24'hfbfc10
`define GEOM_W54_LIMIT       24'h00ffff
`define DEF_CYLINDERS        16'h3fff
`define DEF_HEADS            8'h10
`define DEF_SECTORS          8'h3f
`define DEF_CAPACITY         32'h00fbfc10
`define DEF_FEATURE_CTRL     2'h3
`define MAX_TRACK_SECTORS    8'h3f

`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// ==== core/seq_divider.v ====
// Restoring sequential divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none

module seq_divider #(
	parameter N = 24,
	parameter D = 12
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire         start,
	input  wire [N-1:0] dividend,
	input  wire [D-1:0] divisor,
	output reg          done,
	output reg  [N-1:0] quotient
);

	reg  [D:0]   rem;
	reg  [N-1:0] shift;
	reg  [5:0]   count;
	reg          active;
	reg  [D-1:0] dvs;
	wire [D+1:0] trial;
	wire [D:0]   rem_sh;

	assign rem_sh = {rem[D-1:0], shift[N-1]};
	assign trial  = {1'b0, rem_sh} - {2'b00, dvs};

	always @(posedge aclk) begin
		if (!aresetn) begin
			rem      <= {(D+1){1'b0}};
			shift    <= {N{1'b0}};
			count    <= 6'h00;
			active   <= 1'b0;
			dvs      <= {D{1'b0}};
			done     <= 1'b0;
			quotient <= {N{1'b0}};
		end else begin
			done <= 1'b0;
			if (start && !active) begin
				rem    <= {(D+1){1'b0}};
				shift  <= dividend;
				dvs    <= divisor;
				count  <= N[5:0];
				active <= 1'b1;
			end else if (active) begin
				// Subtract only when it does not borrow
				if (!trial[D+1]) begin
					rem   <= trial[D:0];
					shift <= {shift[N-2:0], 1'b1};
				end else begin
					rem   <= rem_sh;
					shift <= {shift[N-2:0], 1'b0};
				end
				count <= count - 6'h01;
				if (count == 6'h01) begin
					active   <= 1'b0;
					done     <= 1'b1;
					quotient <= {shift[N-2:0], ~trial[D+1]};
				end
			end
		end
	end

endmodule // seq_divider

`default_nettype wire

// ==== testbench/geom_media_checker_assertions.sv ====
// Port checker for the geometry and media command block
`timescale 1ns/1ps
`default_nettype none
module geom_media_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        ops_pending,
	input wire logic        spindle_stopped,
	input wire logic        spin_down_req,
	input wire logic        eject_pulse
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	b_follows_a: assert property (aw_take |=> s_axi_bvalid)
		else $error("write answer missing");
	b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_follows_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer missing");
	r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	unmapped_read_a: assert property (ar_take && s_axi_araddr >= 8'h34
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
	eject_single_a: assert property (eject_pulse |=> !eject_pulse)
		else $error("eject pulse too long");
	eject_after_spin_a: assert property (eject_pulse |-> !spin_down_req && spindle_stopped)
		else $error("eject before spin down");
	spin_after_idle_a: assert property ($rose(spin_down_req) |-> $past(ops_pending, 3) == 1'b0)
		else $error("spin down with work pending");
	spin_holds_a: assert property (spin_down_req && !spindle_stopped |=> spin_down_req)
		else $error("spin down dropped early");
	// Main scenarios reached
	eject_c: cover property (eject_pulse);
	spin_c: cover property ($rose(spin_down_req));
	unmapped_c: cover property (ar_take && s_axi_araddr == 8'h34);
endmodule // geom_media_checker

bind geometry_and_media_cmds geom_media_checker chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ops_pending,
	.spindle_stopped, .spin_down_req, .eject_pulse);
`default_nettype wire

// ==== testbench/media_mech.sv ====
// Behavioural drive mechanism on the far side of the command block
`timescale 1ns/1ps
`default_nettype none
module media_mech (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       insert,
	input  wire logic       fault_in,
	input  wire logic [3:0] delay,
	input  wire logic       spin_down_req,
	input  wire logic       eject_pulse,
	output var  logic       medium_present,
	output wire logic       ops_pending,
	output var  logic       spindle_stopped,
	output wire logic       unit_fault
);
	// ****************
	// Mechanism
	// ****************
	logic [3:0] pend_cnt;
	logic [3:0] spin_cnt;
	assign unit_fault  = fault_in;
	assign ops_pending = pend_cnt != 4'h0;
	// Insertion spins up and leaves work pending, so eject must wait
	always @(posedge aclk) begin
		if (!aresetn || insert) begin
			medium_present  <= 1'b1;
			pend_cnt        <= delay;
			spin_cnt        <= 4'h0;
			spindle_stopped <= 1'b0;
		end else begin
			if (pend_cnt != 4'h0)
				pend_cnt <= pend_cnt - 4'h1;
			if (spin_down_req && spin_cnt != delay)
				spin_cnt <= spin_cnt + 4'h1;
			if (spin_down_req && spin_cnt == delay)
				spindle_stopped <= 1'b1;
			if (eject_pulse)
				medium_present <= 1'b0;
		end
	end
endmodule // media_mech
`default_nettype wire

// ==== testbench/geometry_and_media_cmds_tb.sv ====
// Self-checking bench for the geometry and media command block
`timescale 1ns/1ps
`default_nettype none
module geometry_and_media_cmds_tb;
	// ****************
	// Bench
	// ****************
	localparam logic [31:0] CAP = 32'h01000000;
	localparam logic [31:0] DEFAULT_GEOM = 32'h3fff103f;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic aclk = 0, aresetn = 0, insert = 0, fault_in = 0;
	logic [3:0] delay = 4'h6;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, medium_present, ops_pending, spindle_stopped, unit_fault;
	logic spin_down_req, eject_pulse;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int errors = 0, check_count = 0, cycles = 0;
	always #5 aclk = ~aclk;
	geometry_and_media_cmds #(.CAPACITY(CAP)) dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .medium_present, .ops_pending, .spindle_stopped, .unit_fault,
		.spin_down_req, .eject_pulse);
	media_mech mech (.aclk, .aresetn, .insert, .fault_in, .delay, .spin_down_req,
		.eject_pulse, .medium_present, .ops_pending, .spindle_stopped, .unit_fault);
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		compare(d, exp);
	endtask
	// Status with the flag left open by geometry masked out
	task automatic chk_st(input logic [31:0] err, input logic [31:0] st);
		chk(8'h00, err);
		rd(8'h04);
		compare(d & 32'hb9, st);
	endtask
	task automatic cmd(input logic [7:0] op);
		wr(8'h0c, {24'h0, op});
		do rd(8'h04); while (d[7] !== 1'b0);
	endtask
	task automatic load();
		insert <= 1'b1;
		@(posedge aclk);
		insert <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic geom(input logic [7:0] sec, input logic [3:0] head);
		int unsigned h, q;
		h = head + 1;
		q = 16514064 / (h * sec);
		if (q > 65535)
			q = 65535;
		wr(8'h10, {24'h0, sec});
		wr(8'h08, {24'h0, 4'h1, head});
		cmd(8'h91);
		chk_st(32'h0, 32'h0);
		chk(8'h1c, 32'h1);
		chk(8'h24, h);
		chk(8'h28, {24'h0, sec});
		chk(8'h20, q);
		chk(8'h2c, q * h * sec);
		chk(8'h08, {24'h0, 4'h1, head});
		chk(8'h30, DEFAULT_GEOM);
		chk(8'h18, CAP);
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(8'h04, 32'h40);
		chk(8'h28, 32'h3f);
		chk(8'h30, DEFAULT_GEOM);
		chk(8'h34, 32'h0);
		compare(r, 2'h2);
		wr(8'h00, 32'h1);
		compare(r, 2'h2);
		geom(8'h11, 4'hf);
		geom(8'h01, 4'h0);
		wr(8'h10, 32'h0);
		cmd(8'h91);
		chk_st(32'h04, 32'h01);
		chk(8'h1c, 32'h0);
		cmd(8'h20);
		chk_st(32'h10, 32'h01);
		geom(8'h3f, 4'h3);
		s_axi_wstrb <= 4'h0;
		wr(8'h10, 32'h5);
		s_axi_wstrb <= 4'hf;
		compare(r, 2'h0);
		chk(8'h10, 32'h3f);
		cmd(8'h30);
		chk_st(32'h04, 32'h01);
		load();
		cmd(8'hde);
		chk(8'h14, 32'h103);
		cmd(8'hed);
		chk(8'h04, 32'h40);
		chk(8'h14, 32'h3);
		cmd(8'hed);
		chk(8'h00, 32'h02);
		chk(8'h04, 32'h41);
		load();
		wr(8'h14, 32'h0);
		cmd(8'hed);
		chk_st(32'h04, 32'h01);
		wr(8'h14, 32'h3);
		fault_in <= 1'b1;
		repeat (4) @(posedge aclk);
		cmd(8'hde);
		chk_st(32'h04, 32'h21);
		fault_in <= 1'b0;
		report_and_stop();
	end
endmodule // geometry_and_media_cmds_tb
`default_nettype wire
